// ---- gfg_top.sv ----
// gfg_top: fast gpio ports with direction, latch, mask and edge flags.
// assumes a single-cycle command port next to the core; pins sampled on i_clock.
`timescale 1ns/1ps
module gfg_top #(
	parameter int NP = gfg_pkg::NUM_PORTS,
	parameter int W = gfg_pkg::PORT_W
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// command port
	input wire gfg_pkg::gfg_wr_s i_wr,
	input wire gfg_pkg::gfg_rd_s i_rd,
	output logic o_rd_valid,
	output logic [W-1:0] o_rd_data,
	// pins
	input wire logic [NP-1:0][W-1:0] i_pin,
	output logic [NP-1:0][W-1:0] o_pin_out,
	output logic [NP-1:0][W-1:0] o_pin_oe,
	// events
	output logic o_irq,
	output logic o_wake
);

	logic [NP-1:0][W-1:0] dir, out_q, mask, rise_en, fall_en, rise_flag, fall_flag;
	logic [NP-1:0] wake_p, irq_p;
	logic [W-1:0] lanes;
	logic rd_valid, next_rd_valid;
	logic [W-1:0] rd_data, next_rd_data;

	assign lanes = gfg_pkg::lane_bits(i_wr.strb);

	genvar p;
	generate
		for (p = 0; p < NP; p++) begin : g_port
			logic hit;
			logic [W-1:0] wm;
			logic [W-1:0] next_dir, next_out, next_mask;
			assign hit = i_wr.valid && (i_wr.port == gfg_pkg::PORT_IDX_W'(p));
			assign wm = lanes & ~mask[p];

			always_comb begin
				next_dir = dir[p];
				next_out = out_q[p];
				next_mask = mask[p];
				if (hit) begin
					case (i_wr.op)
						gfg_pkg::OP_DIR: next_dir = (dir[p] & ~lanes) | (i_wr.data & lanes);
						gfg_pkg::OP_OUT: next_out = (out_q[p] & ~wm) | (i_wr.data & wm);
						gfg_pkg::OP_SET: next_out = out_q[p] | (i_wr.data & wm);
						gfg_pkg::OP_CLR: next_out = out_q[p] & ~(i_wr.data & wm);
						gfg_pkg::OP_MASK: next_mask = (mask[p] & ~lanes) | (i_wr.data & lanes);
						default: ;
					endcase
				end
			end

			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					dir[p] <= gfg_pkg::RST_DIR;
					out_q[p] <= gfg_pkg::RST_OUT;
					mask[p] <= gfg_pkg::RST_MASK;
				end else begin
					dir[p] <= next_dir;
					out_q[p] <= next_out;
					mask[p] <= next_mask;
				end
			end

			assign o_pin_out[p] = out_q[p];
			assign o_pin_oe[p] = dir[p];

			if (gfg_pkg::edge_pins(p) != '0) begin : g_edge
				localparam logic [W-1:0] EP = W'(gfg_pkg::edge_pins(p));
				logic [W-1:0] rise, fall, wc;
				logic [W-1:0] next_ren, next_fen, next_rfl, next_ffl;
				assign wc = i_wr.data & lanes;

				gfg_edge #(.W(W)) u_edge (
					.i_clock(i_clock),
					.i_rst_n(i_rst_n),
					.i_pin(i_pin[p]),
					.i_rise_en(rise_en[p]),
					.i_fall_en(fall_en[p]),
					.o_rise(rise),
					.o_fall(fall),
					.o_wake(wake_p[p])
				);

				always_comb begin
					next_ren = rise_en[p];
					next_fen = fall_en[p];
					next_rfl = rise_flag[p];
					next_ffl = fall_flag[p];
					if (hit && i_wr.op == gfg_pkg::OP_RISE_EN) begin
						next_ren = ((rise_en[p] & ~lanes) | wc) & EP;
					end
					if (hit && i_wr.op == gfg_pkg::OP_FALL_EN) begin
						next_fen = ((fall_en[p] & ~lanes) | wc) & EP;
					end
					if (hit && i_wr.op == gfg_pkg::OP_RISE_CLR) begin
						next_rfl = rise_flag[p] & ~wc;
					end
					if (hit && i_wr.op == gfg_pkg::OP_FALL_CLR) begin
						next_ffl = fall_flag[p] & ~wc;
					end
					// a new edge in the clearing cycle survives the clear
					next_rfl = next_rfl | rise;
					next_ffl = next_ffl | fall;
				end

				always_ff @(posedge i_clock or negedge i_rst_n) begin
					if (!i_rst_n) begin
						rise_en[p] <= gfg_pkg::RST_EDGE;
						fall_en[p] <= gfg_pkg::RST_EDGE;
						rise_flag[p] <= gfg_pkg::RST_EDGE;
						fall_flag[p] <= gfg_pkg::RST_EDGE;
					end else begin
						rise_en[p] <= next_ren;
						fall_en[p] <= next_fen;
						rise_flag[p] <= next_rfl;
						fall_flag[p] <= next_ffl;
					end
				end

				assign irq_p[p] = |((rise_flag[p] & rise_en[p]) | (fall_flag[p] & fall_en[p]));
			end else begin : g_plain
				assign rise_en[p] = '0;
				assign fall_en[p] = '0;
				assign rise_flag[p] = '0;
				assign fall_flag[p] = '0;
				assign wake_p[p] = 1'b0;
				assign irq_p[p] = 1'b0;
			end
		end
	endgenerate

	assign o_irq = |irq_p;
	assign o_wake = |wake_p;

	// read path: one registered cycle keeps the mux off the pin timing
	always_comb begin
		next_rd_valid = i_rd.req;
		next_rd_data = rd_data;
		if (i_rd.req && (i_rd.port < gfg_pkg::PORT_IDX_W'(NP))) begin
			case (i_rd.sel)
				gfg_pkg::RD_DIR: next_rd_data = dir[i_rd.port];
				gfg_pkg::RD_OUT: next_rd_data = out_q[i_rd.port];
				gfg_pkg::RD_PIN: next_rd_data = i_pin[i_rd.port] & ~mask[i_rd.port];
				gfg_pkg::RD_MASK: next_rd_data = mask[i_rd.port];
				gfg_pkg::RD_RISE_EN: next_rd_data = rise_en[i_rd.port];
				gfg_pkg::RD_FALL_EN: next_rd_data = fall_en[i_rd.port];
				gfg_pkg::RD_RISE_FLAG: next_rd_data = rise_flag[i_rd.port];
				gfg_pkg::RD_FALL_FLAG: next_rd_data = fall_flag[i_rd.port];
				default: next_rd_data = '0;
			endcase
		end else if (i_rd.req) begin
			next_rd_data = '0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else begin
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
		end
	end

	assign o_rd_valid = rd_valid;
	assign o_rd_data = rd_data;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	sequence s_set_p0;
		i_wr.valid && i_wr.port == 3'h0 && i_wr.op == gfg_pkg::OP_SET;
	endsequence

	sequence s_clr_p0;
		i_wr.valid && i_wr.port == 3'h0 && i_wr.op == gfg_pkg::OP_CLR;
	endsequence

	chk_set_drives_high: assert property (s_set_p0 |=>
		((out_q[0] & $past(i_wr.data & lanes & ~mask[0])) == $past(i_wr.data & lanes & ~mask[0])))
		else $error("set did not raise chosen bits");

	chk_clr_drives_low: assert property (s_clr_p0 |=>
		((out_q[0] & $past(i_wr.data & lanes & ~mask[0])) == 32'h0000_0000))
		else $error("clear did not lower chosen bits");

	chk_mask_keeps_bits: assert property ((i_wr.valid && i_wr.port == 3'h0) |=>
		((out_q[0] & $past(mask[0])) == ($past(out_q[0]) & $past(mask[0]))))
		else $error("masked bit changed");

	chk_lane_isolation: assert property ((i_wr.valid && i_wr.port == 3'h1 && !i_wr.strb[0]) |=>
		(out_q[1][7:0] == $past(out_q[1][7:0]) && dir[1][7:0] == $past(dir[1][7:0])))
		else $error("unaddressed lane changed");

	chk_whole_write: assert property ((i_wr.valid && i_wr.port == 3'h1 && i_wr.op == gfg_pkg::OP_OUT
		&& i_wr.strb == 4'hf && mask[1] == 32'h0000_0000) |=> out_q[1] == $past(i_wr.data))
		else $error("whole port write not applied");

	chk_read_latency: assert property ((i_rd.req && i_rd.sel == gfg_pkg::RD_OUT && i_rd.port == 3'h2)
		|=> (o_rd_valid && o_rd_data == $past(out_q[2])))
		else $error("latch read wrong or late");

	chk_dir_oe: assert property (o_pin_oe == dir && o_pin_out == out_q)
		else $error("driver does not follow direction");

	chk_flag_sticky: assert property ((rise_flag[0][0] && !(i_wr.valid && i_wr.port == 3'h0
		&& i_wr.op == gfg_pkg::OP_RISE_CLR && i_wr.strb[0] && i_wr.data[0])) |=> rise_flag[0][0])
		else $error("flag dropped without clear");

	chk_irq_level: assert property (o_irq == |((rise_flag[0] & rise_en[0]) | (fall_flag[0] & fall_en[0])
		| (rise_flag[2] & rise_en[2]) | (fall_flag[2] & fall_en[2])))
		else $error("interrupt does not match enabled flags");

	chk_rise_flags: assert property ((rise_en[0][3] && !i_pin[0][3]) ##1 (rise_en[0][3] && i_pin[0][3])
		|=> rise_flag[0][3])
		else $error("enabled rise not flagged");

	// wake is pure gating against the held sample, so it must stand before the next edge
	chk_wake_on_edge: assert property ((rise_en[0][3] && !i_pin[0][3]) ##1 (rise_en[0][3] && i_pin[0][3])
		|-> o_wake)
		else $error("enabled edge gave no wake request");

	chk_reset_inputs: assert property ($rose(i_rst_n) |-> o_pin_oe == '0)
		else $error("pin driven after reset");

endmodule

// ---- gfg_pkg.sv ----
// gfg_pkg: constants, command encodings and carrier types for the fast gpio block.
// assumes one 25 MHz clock and a single-cycle command port driven by the owner.
package gfg_pkg;

	localparam int NUM_PORTS = 5;
	localparam int PORT_W = 32;
	localparam int PORT_IDX_W = 3;
	localparam int LANES = 4;
	localparam int FIRST_EDGE_PORT = 0;
	localparam int THIRD_EDGE_PORT = 2;
	localparam int EDGE_PIN_COUNT = 42;
	localparam logic [31:0] FIRST_EDGE_PINS = 32'hffff_ffff;
	localparam logic [31:0] THIRD_EDGE_PINS = 32'h0000_03ff;
	localparam logic [31:0] RST_DIR = 32'h0000_0000;
	localparam logic [31:0] RST_OUT = 32'h0000_0000;
	localparam logic [31:0] RST_MASK = 32'h0000_0000;
	localparam logic [31:0] RST_EDGE = 32'h0000_0000;
	localparam int RD_LATENCY = 1;

	typedef enum logic [3:0] {
		OP_DIR,
		OP_OUT,
		OP_SET,
		OP_CLR,
		OP_MASK,
		OP_RISE_EN,
		OP_FALL_EN,
		OP_RISE_CLR,
		OP_FALL_CLR
	} gfg_op_e;

	typedef enum logic [2:0] {
		RD_DIR,
		RD_OUT,
		RD_PIN,
		RD_MASK,
		RD_RISE_EN,
		RD_FALL_EN,
		RD_RISE_FLAG,
		RD_FALL_FLAG
	} gfg_rd_e;

	typedef struct packed {
		logic valid;
		gfg_op_e op;
		logic [PORT_IDX_W-1:0] port;
		logic [LANES-1:0] strb;
		logic [PORT_W-1:0] data;
	} gfg_wr_s;

	typedef struct packed {
		logic req;
		gfg_rd_e sel;
		logic [PORT_IDX_W-1:0] port;
	} gfg_rd_s;

	// expands byte strobes into a bit mask so narrow writes touch only their lanes
	function automatic logic [PORT_W-1:0] lane_bits(input logic [LANES-1:0] strb);
		logic [PORT_W-1:0] m;
		m = '0;
		for (int i = 0; i < LANES; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction

	// which pins of a port may raise edge events; ports without edge logic give zero
	function automatic logic [PORT_W-1:0] edge_pins(input int p);
		if (p == FIRST_EDGE_PORT) begin
			return FIRST_EDGE_PINS;
		end
		if (p == THIRD_EDGE_PORT) begin
			return THIRD_EDGE_PINS;
		end
		return '0;
	endfunction

endpackage

// ---- gfg_edge.sv ----
// gfg_edge: per-pin edge detector for one edge-capable port.
// assumes pins are synchronous to i_clock while it runs; wake path needs no clock.
`timescale 1ns/1ps
module gfg_edge #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// pins and enables
	input wire logic [W-1:0] i_pin,
	input wire logic [W-1:0] i_rise_en,
	input wire logic [W-1:0] i_fall_en,
	// events
	output logic [W-1:0] o_rise,
	output logic [W-1:0] o_fall,
	output logic o_wake
);

	logic [W-1:0] prev;
	logic armed;
	logic [W-1:0] next_prev;
	logic next_armed;

	always_comb begin
		next_prev = i_pin;
		next_armed = 1'b1;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev <= '0;
			armed <= 1'b0;
		end else begin
			prev <= next_prev;
			armed <= next_armed;
		end
	end

	// the first sample after reset only arms, so a high pin is not taken as a rise
	assign o_rise = armed ? (i_pin & ~prev & i_rise_en) : '0;
	assign o_fall = armed ? (~i_pin & prev & i_fall_en) : '0;
	// pure gates against the held sample: still fires with the clock stopped
	assign o_wake = |(o_rise | o_fall);

endmodule

// ---- gfg_pins.sv ----
// gfg_pins: pad model standing between the gpio block and the board.
// assumes one board level per pin, overridden wherever the block drives the pad.
`timescale 1ns/1ps
module gfg_pins (
	// block side
	input wire logic [4:0][31:0] i_pin_out,
	input wire logic [4:0][31:0] i_pin_oe,
	// board side
	input wire logic [4:0][31:0] i_ext,
	output logic [4:0][31:0] o_pin
);
	// a driven pad shows the latch, an undriven one shows the board level
	assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule

// ---- gfg_top_bench.sv ----
// gfg_top_bench: directed checks of the fast gpio block through its command port.
// assumes the pad model above; all inputs move 1 ns after a rising edge.
`timescale 1ns/1ps
module gfg_top_bench;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	gfg_pkg::gfg_wr_s i_wr = '0;
	gfg_pkg::gfg_rd_s i_rd = '0;
	logic o_rd_valid;
	logic o_irq;
	logic o_wake;
	logic [31:0] o_rd_data;
	logic [4:0][31:0] pin;
	logic [4:0][31:0] pin_out;
	logic [4:0][31:0] pin_oe;
	logic [4:0][31:0] ext = '0;
	int err_total = 0;
	int checked = 0;

	always #20 i_clock = ~i_clock;

	gfg_top u_gfg_top (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rd_valid(o_rd_valid),
		.o_rd_data(o_rd_data),
		.i_pin(pin),
		.o_pin_out(pin_out),
		.o_pin_oe(pin_oe),
		.o_irq(o_irq),
		.o_wake(o_wake)
	);

	gfg_pins u_gfg_pins (
		.i_pin_out(pin_out),
		.i_pin_oe(pin_oe),
		.i_ext(ext),
		.o_pin(pin)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// a write is held for exactly one taking edge; the next task replaces it
	task automatic wr(input gfg_pkg::gfg_op_e op, input logic [2:0] port,
		input logic [3:0] strb, input logic [31:0] data);
		i_wr = '{1'b1, op, port, strb, data};
		i_rd.req = 1'b0;
		@(posedge i_clock);
		#1;
	endtask

	// read answer is registered on the taking edge itself, so look 1 ns after it
	task automatic rd(input gfg_pkg::gfg_rd_e sel, input logic [2:0] port,
		input logic [31:0] exp);
		i_rd = '{1'b1, sel, port};
		i_wr.valid = 1'b0;
		@(posedge i_clock);
		#1;
		chk(o_rd_valid, 32'h0000_0001);
		chk(o_rd_data, exp);
	endtask

	task automatic idle(input int n);
		i_wr.valid = 1'b0;
		i_rd.req = 1'b0;
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	task automatic close_out;
		$display("counts checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// generous bound: the directed sequence needs well under 200 cycles
	initial begin
		#40000;
		err_total++;
		close_out();
	end

	initial begin
		repeat (10) @(posedge i_clock);
		#1;
		for (int p = 0; p < 5; p++) begin
			chk(pin_oe[p], 32'h0000_0000);
			chk(pin_out[p], 32'h0000_0000);
		end
		chk(o_irq, 32'h0000_0000);
		i_rst_n = 1'b1;
		idle(1);
		$display("test reset done");

		wr(gfg_pkg::OP_DIR, 3'h1, 4'hf, 32'hffff_0000);
		wr(gfg_pkg::OP_OUT, 3'h1, 4'hf, 32'ha5a5_5a5a);
		wr(gfg_pkg::OP_DIR, 3'h1, 4'h3, 32'h0000_ffff);
		rd(gfg_pkg::RD_DIR, 3'h1, 32'hffff_ffff);
		rd(gfg_pkg::RD_OUT, 3'h1, 32'ha5a5_5a5a);
		chk(pin_oe[1], 32'hffff_ffff);
		chk(pin_out[1], 32'ha5a5_5a5a);
		rd(gfg_pkg::RD_PIN, 3'h1, 32'ha5a5_5a5a);
		ext[1] = 32'h3c3c_0000;
		wr(gfg_pkg::OP_DIR, 3'h1, 4'hc, 32'h0000_0000);
		rd(gfg_pkg::RD_PIN, 3'h1, 32'h3c3c_5a5a);
		rd(gfg_pkg::RD_OUT, 3'h5, 32'h0000_0000);
		$display("test direction done");

		wr(gfg_pkg::OP_SET, 3'h1, 4'hf, 32'h0000_00f0);
		wr(gfg_pkg::OP_CLR, 3'h1, 4'hf, 32'ha000_000a);
		rd(gfg_pkg::RD_OUT, 3'h1, 32'h05a5_5af0);
		wr(gfg_pkg::OP_OUT, 3'h1, 4'h2, 32'hffff_ffff);
		wr(gfg_pkg::OP_SET, 3'h1, 4'h8, 32'hffff_ffff);
		rd(gfg_pkg::RD_OUT, 3'h1, 32'hffa5_fff0);
		wr(gfg_pkg::OP_MASK, 3'h1, 4'hf, 32'hffff_0000);
		wr(gfg_pkg::OP_OUT, 3'h1, 4'hf, 32'h0000_0000);
		rd(gfg_pkg::RD_OUT, 3'h1, 32'hffa5_0000);
		rd(gfg_pkg::RD_PIN, 3'h1, 32'h0000_0000);
		rd(gfg_pkg::RD_MASK, 3'h1, 32'hffff_0000);
		wr(gfg_pkg::OP_MASK, 3'h1, 4'hf, 32'h0000_0000);
		$display("test latch done");

		wr(gfg_pkg::OP_RISE_EN, 3'h2, 4'hf, 32'hffff_ffff);
		wr(gfg_pkg::OP_RISE_EN, 3'h1, 4'hf, 32'hffff_ffff);
		wr(gfg_pkg::OP_RISE_EN, 3'h0, 4'hf, 32'h0000_0008);
		wr(gfg_pkg::OP_FALL_EN, 3'h0, 4'hf, 32'h0000_0020);
		rd(gfg_pkg::RD_RISE_EN, 3'h2, 32'h0000_03ff);
		rd(gfg_pkg::RD_RISE_EN, 3'h1, 32'h0000_0000);
		rd(gfg_pkg::RD_FALL_EN, 3'h0, 32'h0000_0020);
		ext[0] = 32'h0000_0028;
		#1;
		chk(o_wake, 32'h0000_0001);
		idle(2);
		chk(o_irq, 32'h0000_0001);
		chk(o_wake, 32'h0000_0000);
		rd(gfg_pkg::RD_RISE_FLAG, 3'h0, 32'h0000_0008);
		rd(gfg_pkg::RD_FALL_FLAG, 3'h0, 32'h0000_0000);
		idle(3);
		chk(o_irq, 32'h0000_0001);
		wr(gfg_pkg::OP_RISE_CLR, 3'h0, 4'hf, 32'h0000_0008);
		idle(2);
		chk(o_irq, 32'h0000_0000);
		ext[0] = 32'h0000_0008;
		ext[2] = 32'h0000_0600;
		idle(2);
		chk(o_irq, 32'h0000_0001);
		rd(gfg_pkg::RD_FALL_FLAG, 3'h0, 32'h0000_0020);
		rd(gfg_pkg::RD_RISE_FLAG, 3'h2, 32'h0000_0200);
		wr(gfg_pkg::OP_FALL_CLR, 3'h0, 4'hf, 32'h0000_0020);
		wr(gfg_pkg::OP_RISE_EN, 3'h2, 4'hf, 32'h0000_0000);
		idle(2);
		chk(o_irq, 32'h0000_0000);
		rd(gfg_pkg::RD_RISE_FLAG, 3'h2, 32'h0000_0200);
		$display("test edges done");
		close_out();
	end
endmodule
